// ==== level_intr_pkg.sv ====
package level_intr_pkg;

   // Level count and widths
   localparam int              LEVEL_COUNT    = 16;
   localparam int              LEVEL_BITS     = 4;
   localparam int              WORD_BITS      = 16;
   localparam logic [3:0]      VIOLATION_LVL  = 4'hE;

   // Internal-register selector used by the register-transfer port
   localparam logic [1:0]      SEL_REQ_LATCH  = 2'h0;
   localparam logic [1:0]      SEL_EN_MASK    = 2'h1;
   localparam logic [1:0]      SEL_PROTECT    = 2'h2;

   // Reset values
   localparam logic [15:0]     REQ_LATCH_RST  = 16'h0000;
   localparam logic [15:0]     EN_MASK_RST    = 16'h0000;
   localparam logic [15:0]     PROTECT_RST    = 16'h0000;

   // Context layout
   localparam int              CTX_WORDS      = 8;
   localparam logic [15:0]     PTR_BASE_RST   = 16'h0000;

   // Level switch timing, in memory cycles
   localparam int              SWITCH_MEM_CYC = 38;
   localparam logic [5:0]      STEP_LAST      = 6'(SWITCH_MEM_CYC - 1);
   localparam logic [5:0]      STEP_OLD_PTR   = 6'h00;
   localparam logic [5:0]      STEP_SAVE_0    = 6'h01;
   localparam logic [5:0]      STEP_NEW_PTR   = 6'h09;
   localparam logic [5:0]      STEP_LOAD_0    = 6'h0A;
   localparam logic [5:0]      STEP_LOAD_END  = 6'h12;

   // Memory cycle length and CPU clock
   localparam int              CLK_PERIOD_NS  = 4;
   localparam int              MEM_CYCLE_NS   = 1000;
   localparam int              MEM_CYCLE_CLKS = MEM_CYCLE_NS / CLK_PERIOD_NS;

   // Protect block sizing
   localparam int              SMALL_MEM_MAX  = 16384;
   localparam int              SMALL_BLK_LOG2 = 10;
   localparam int              BLOCK_COUNT_L2 = 4;

   typedef enum logic [1:0] {SW_IDLE, SW_RUN, SW_DONE} switch_state_e;

endpackage

// ==== priority_level_interrupt_protect.sv ====
// Behaviour
// R1: Sixteen levels, each with own context
// R2: Levels 0..15, fifteen highest priority
// R3: Requests from lines, program, or CPU
// R4: Two 16-bit registers, one bit per level
// R5: Request bit holds until cleared
// R6: Violation source hardwired to fixed level
// R7: Shared lines OR into one level
// R8: Request bit clears when service done
// R9: Give-up wait clears running level bit
// R10: Enable mask written by program only
// R11: Level runs only while enabled; code keeps a disabled running level running while no other level is active
// R12: Highest requested and enabled level runs
// R13: Save old context, load new context
// R14: One fixed pointer word per level
// R15: Save area is eight consecutive words
// R16: Level switch takes 38 memory cycles
// R17: Protect flags loaded/read via accumulator
// R18: Block size from memory size
// R19: Privileged op from unprotected block refused
// R20: Jump into protected from unprotected refused
// R21: Store into protected from unprotected refused
// R22: Violation raises level 14, else wait
// R23: Switch only at instruction boundary
`timescale 1ns/1ns
module priority_level_interrupt_protect
   import level_intr_pkg::*;
#(
   parameter int          MEM_WORDS  = 65536,
   parameter int          MEM_CYC    = MEM_CYCLE_CLKS,
   parameter logic [15:0] PTR_BASE   = PTR_BASE_RST,
   parameter bit          PRIO_FITTED = 1'b1
)
(
   input  wire logic        sys_clk,        // CPU clock
   input  wire logic        rstn,           // Async reset, active low
   input  wire logic [15:0] extReq,         // External request lines
   input  wire logic [15:0] cpuReq,         // Internal CPU condition requests
   input  wire logic        regWrEn,        // Load internal register
   input  wire logic        regRdEn,        // Read internal register
   input  wire logic [1:0]  regSel,         // Internal register selector
   input  wire logic [15:0] regWrData,      // Accumulator value to load
   output logic      [15:0] regRdData,      // Value for accumulator
   input  wire logic        serviceDone,    // Request on a level serviced
   input  wire logic [3:0]  serviceLevel,   // Level that was serviced
   input  wire logic        giveUpWait,     // Wait instruction executed
   input  wire logic        instrBoundary,  // Between two instructions
   output logic             switchBusy,     // Level switch in progress
   output logic [3:0]       runLevel,       // Level now running
   output logic             runValid,       // Some level is running
   output logic [2:0]       ctxIndex,       // Context word being moved
   input  wire logic [15:0] ctxSaveData,    // CPU context word to save
   output logic             ctxLoadStrobe,  // Load context word into CPU
   output logic      [15:0] ctxLoadData,    // Context word to load
   output logic             memRd,          // Memory read this cycle
   output logic             memWr,          // Memory write this cycle
   output logic      [15:0] memAddr,        // Memory address
   output logic      [15:0] memWrData,      // Memory write data
   input  wire logic [15:0] memRdData,      // Memory read data
   input  wire logic        instrCheck,     // Instruction decoded
   input  wire logic        isPrivileged,   // Privileged op class
   input  wire logic        isJump,         // Jump or op to counter
   input  wire logic        isStore,        // Store or increment memory
   input  wire logic [15:0] fetchAddr,      // Address instruction came from
   input  wire logic [15:0] targetAddr,     // Effective address
   output logic             instrSuppress,  // Do not execute instruction
   output logic             violationWait   // Treat as wait, no level system
);

   localparam int BLK_L2 = (MEM_WORDS <= SMALL_MEM_MAX) ? SMALL_BLK_LOG2
                           : $clog2(MEM_WORDS) - BLOCK_COUNT_L2;

   logic [15:0]    level_request_latch_reg;
   logic [15:0]    level_enable_mask_reg;
   logic [15:0]    block_protect_flags_reg;
   logic [15:0]    reqSetVec;
   logic [15:0]    reqClrVec;
   logic [15:0]    activeVec;
   logic [3:0]     bestLevel;
   logic           bestValid;
   logic           fetchProt;
   logic           targetProt;
   logic           violation;
   logic [15:0]    tickCnt_reg;
   logic           memTick;
   switch_state_e  sw_reg;
   logic [5:0]     step_reg;
   logic [3:0]     newLevel_reg;
   logic [15:0]    oldPtr_reg;
   logic [15:0]    newPtr_reg;

   // Block flag for an address; block index is the four address bits starting at bit BLK_L2
   function automatic logic isProtected(input logic [15:0] a,
                                        input logic [15:0] flags);
      logic [15:0] blk;
      blk = a >> BLK_L2;
      return flags[blk[3:0]];
   endfunction

   assign fetchProt  = isProtected(fetchAddr, block_protect_flags_reg); // R18
   assign targetProt = isProtected(targetAddr, block_protect_flags_reg);

   // Only code in unprotected blocks is policed
   always_comb
   begin
      violation = 1'b0;
      if (instrCheck && !fetchProt)
      begin
         if (isPrivileged)
            violation = 1'b1; // R19
         if (isJump && targetProt)
            violation = 1'b1; // R20
         if (isStore && targetProt)
            violation = 1'b1; // R21
      end
   end

   assign instrSuppress = violation;                     // R19
   assign violationWait = violation && !PRIO_FITTED;     // R22

   // Shared lines arrive already ORed per level
   always_comb
   begin
      reqSetVec = extReq | cpuReq;                       // R3 R7
      if (violation && PRIO_FITTED)
         reqSetVec[VIOLATION_LVL] = 1'b1;                // R6 R22
      if (regWrEn && regSel == SEL_REQ_LATCH)
         reqSetVec = reqSetVec | regWrData;
   end

   always_comb
   begin
      reqClrVec = 16'h0000;
      if (regWrEn && regSel == SEL_REQ_LATCH)
         reqClrVec = ~regWrData;
      if (serviceDone)
         reqClrVec[serviceLevel] = 1'b1;                 // R8
      if (giveUpWait && runValid)
         reqClrVec[runLevel] = 1'b1;                     // R9
   end

   // Set beats clear so no request is lost
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         level_request_latch_reg <= REQ_LATCH_RST;
      else
         level_request_latch_reg <= (level_request_latch_reg & ~reqClrVec)
                                    | reqSetVec;         // R4 R5
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         level_enable_mask_reg <= EN_MASK_RST;
      else if (regWrEn && regSel == SEL_EN_MASK)
         level_enable_mask_reg <= regWrData;             // R10
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         block_protect_flags_reg <= PROTECT_RST;
      else if (regWrEn && regSel == SEL_PROTECT)
         block_protect_flags_reg <= regWrData;           // R17
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         regRdData <= 16'h0000;
      else if (regRdEn)
      begin
         case (regSel)
            SEL_REQ_LATCH: regRdData <= level_request_latch_reg;
            SEL_EN_MASK:   regRdData <= level_enable_mask_reg;
            SEL_PROTECT:   regRdData <= block_protect_flags_reg; // R17
            default:       regRdData <= 16'h0000;
         endcase
      end
   end

   // Priority pick: scan upward so the highest level wins
   assign activeVec = level_request_latch_reg & level_enable_mask_reg; // R11
   always_comb
   begin
      bestLevel = 4'h0;
      bestValid = 1'b0;
      for (int i = 0; i < LEVEL_COUNT; i++)
      begin
         if (activeVec[i])
         begin
            bestLevel = 4'(i);                           // R2 R12
            bestValid = 1'b1;
         end
      end
   end

   // Memory-cycle enable
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         tickCnt_reg <= 16'h0000;
      else if (sw_reg != SW_RUN || memTick)
         tickCnt_reg <= 16'h0000;
      else
         tickCnt_reg <= tickCnt_reg + 16'h0001;
   end
   assign memTick = (sw_reg == SW_RUN) && (tickCnt_reg == 16'(MEM_CYC - 1));

   // Switch sequencer; pointer reads and context moves take fixed slots
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sw_reg       <= SW_IDLE;
         step_reg     <= 6'h00;
         newLevel_reg <= 4'h0;
         runLevel     <= 4'h0;
         runValid     <= 1'b0;
      end
      else
      begin
         case (sw_reg)
            SW_IDLE:
            begin
               if (instrBoundary && bestValid
                   && (!runValid || bestLevel != runLevel))
               begin
                  newLevel_reg <= bestLevel;             // R23
                  step_reg     <= 6'h00;
                  sw_reg       <= SW_RUN;
               end
            end
            SW_RUN:
            begin
               if (memTick)
               begin
                  if (step_reg == STEP_LAST)
                     sw_reg <= SW_DONE;                  // R16
                  else
                     step_reg <= step_reg + 6'h01;
               end
            end
            SW_DONE:
            begin
               runLevel <= newLevel_reg;                 // R1
               runValid <= 1'b1;
               sw_reg   <= SW_IDLE;
            end
            default:
               sw_reg <= SW_IDLE;
         endcase
      end
   end

   // Level pointers and loaded words are captured at the end of their slot
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         oldPtr_reg    <= 16'h0000;
         newPtr_reg    <= 16'h0000;
         ctxLoadData   <= 16'h0000;
         ctxLoadStrobe <= 1'b0;
      end
      else
      begin
         ctxLoadStrobe <= 1'b0;
         if (memTick && step_reg == STEP_OLD_PTR)
            oldPtr_reg <= memRdData;                     // R14
         if (memTick && step_reg == STEP_NEW_PTR)
            newPtr_reg <= memRdData;                     // R14
         if (memTick && step_reg >= STEP_LOAD_0
             && step_reg < STEP_LOAD_END)
         begin
            ctxLoadData   <= memRdData;                  // R13
            ctxLoadStrobe <= 1'b1;
         end
      end
   end

   // A first switch from reset has no old context, so its save is skipped
   always_comb
   begin
      memRd     = 1'b0;
      memWr     = 1'b0;
      memAddr   = 16'h0000;
      memWrData = ctxSaveData;
      ctxIndex  = 3'h0;
      if (sw_reg == SW_RUN)
      begin
         if (step_reg == STEP_OLD_PTR && runValid)
         begin
            memRd   = 1'b1;
            memAddr = PTR_BASE + {12'h000, runLevel};    // R14
         end
         else if (step_reg >= STEP_SAVE_0 && step_reg < STEP_NEW_PTR)
         begin
            ctxIndex = 3'(step_reg - STEP_SAVE_0);
            memWr    = runValid;                         // R13
            memAddr  = oldPtr_reg + {13'h0000, ctxIndex}; // R15
         end
         else if (step_reg == STEP_NEW_PTR)
         begin
            memRd   = 1'b1;
            memAddr = PTR_BASE + {12'h000, newLevel_reg};
         end
         else if (step_reg >= STEP_LOAD_0 && step_reg < STEP_LOAD_END)
         begin
            ctxIndex = 3'(step_reg - STEP_LOAD_0);
            memRd    = 1'b1;                             // R13
            memAddr  = newPtr_reg + {13'h0000, ctxIndex}; // R15
         end
      end
   end

   assign switchBusy = (sw_reg != SW_IDLE);

   // Helper: clocks spent in one switch
   logic [15:0] swClk_reg;
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         swClk_reg <= 16'h0000;
      else if (sw_reg == SW_RUN)
         swClk_reg <= swClk_reg + 16'h0001;
      else
         swClk_reg <= 16'h0000;
   end

   a_switch_length: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sw_reg == SW_RUN && memTick && step_reg == STEP_LAST)
      |-> swClk_reg == 16'(SWITCH_MEM_CYC * MEM_CYC - 1)) // R16
      else $error("level switch length wrong");

   a_switch_boundary: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sw_reg == SW_RUN && $past(sw_reg) == SW_IDLE)
      |-> $past(instrBoundary)) // R23
      else $error("switch began off boundary");

   // Shift test is independent of the scan loop above
   a_pick_highest: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sw_reg == SW_RUN && $past(sw_reg) == SW_IDLE)
      |-> ($past(activeVec) >> newLevel_reg) == 16'h0001) // R12
      else $error("chosen level not highest active");

   a_run_highest: assert property (@(posedge sys_clk) disable iff (!rstn)
      (sw_reg == SW_DONE) |=> runLevel == $past(newLevel_reg)
      && level_enable_mask_reg[runLevel] | !$past(activeVec[newLevel_reg]))
      // R12
      else $error("switched level not the chosen one");

   a_wait_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
      (giveUpWait && runValid && !reqSetVec[runLevel])
      |=> !level_request_latch_reg[$past(runLevel)]) // R9
      else $error("wait did not clear running level");

   a_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
      (serviceDone && reqSetVec[serviceLevel])
      |=> level_request_latch_reg[$past(serviceLevel)]) // R5
      else $error("request lost on clear");

   a_violation_lvl: assert property (@(posedge sys_clk) disable iff (!rstn)
      (instrCheck && !fetchProt && isPrivileged && PRIO_FITTED)
      |-> instrSuppress ##1 level_request_latch_reg[VIOLATION_LVL]) // R22
      else $error("violation did not raise level");

   a_mask_program: assert property (@(posedge sys_clk) disable iff (!rstn)
      !(regWrEn && regSel == SEL_EN_MASK)
      |=> $stable(level_enable_mask_reg)) // R10
      else $error("enable mask changed without program");

   a_protected_free: assert property (@(posedge sys_clk) disable iff (!rstn)
      fetchProt |-> !instrSuppress) // R19
      else $error("protected code was refused");

   a_save_window: assert property (@(posedge sys_clk) disable iff (!rstn)
      memWr |-> step_reg >= STEP_SAVE_0 && step_reg < STEP_NEW_PTR
      && memAddr == oldPtr_reg + {13'h0000, ctxIndex}) // R15
      else $error("save write outside save area");

endmodule

// ==== cpu_memory_model.sv ====
`timescale 1ns/1ns
module cpu_memory_model
(
   input  wire logic        sys_clk,     // CPU clock
   input  wire logic        memRd,       // Read request
   input  wire logic        memWr,       // Write request
   input  wire logic [15:0] memAddr,     // Word address
   input  wire logic [15:0] memWrData,   // Write data
   output logic      [15:0] memRdData,   // Read data
   input  wire logic [2:0]  ctxIndex,    // Context word selector
   input  wire logic [3:0]  runLevel,    // Level being saved
   output logic      [15:0] ctxSaveData  // CPU context word
);
   logic [15:0] mem [256];
   logic [15:0] lastRd;

   // Pointer words at 0..15, save areas from 0x20 on, rest a ramp
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'h1000 + 16'(i);
      for (int l = 0; l < 16; l++)
         mem[l] = 16'h0020 + 16'(8 * l);
      lastRd = 16'h0000;
   end

   // Released bus shows the inverse so stale data never looks valid
   assign memRdData = memRd ? mem[memAddr[7:0]] : ~lastRd;

   // Context word names its index and owning level
   assign ctxSaveData = {8'hC0, 1'b0, ctxIndex, runLevel};

   always @(posedge sys_clk)
   begin
      if (memWr)
         mem[memAddr[7:0]] <= memWrData;
      if (memRd)
         lastRd <= mem[memAddr[7:0]];
   end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
   import level_intr_pkg::*;
   localparam int MC = 2;
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] extReq = 16'h0000;
   logic [15:0] cpuReq = 16'h0000;
   logic        regWrEn = 1'b0;
   logic        regRdEn = 1'b0;
   logic [1:0]  regSel = 2'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        serviceDone = 1'b0;
   logic [3:0]  serviceLevel = 4'h0;
   logic        giveUpWait = 1'b0;
   logic        instrBoundary = 1'b0;
   logic        instrCheck = 1'b0;
   logic        isPrivileged = 1'b0;
   logic        isJump = 1'b0;
   logic        isStore = 1'b0;
   logic [15:0] fetchAddr = 16'h0000;
   logic [15:0] targetAddr = 16'h0000;
   logic [15:0] regRdData, ctxSaveData, ctxLoadData, memAddr, memWrData;
   logic [15:0] memRdData, rd;
   logic [3:0]  runLevel;
   logic [2:0]  ctxIndex;
   logic        switchBusy, runValid, ctxLoadStrobe, memRd, memWr;
   logic        instrSuppress, violationWait;
   logic [15:0] loadQ [$];
   int          n_errors = 0;
   int          checked = 0;

   priority_level_interrupt_protect #(.MEM_WORDS(16384), .MEM_CYC(MC),
      .PTR_BASE(16'h0000), .PRIO_FITTED(1'b1)) i_priority_level_interrupt_protect
      (.sys_clk(sys_clk), .rstn(rstn), .extReq(extReq), .cpuReq(cpuReq),
       .regWrEn(regWrEn), .regRdEn(regRdEn), .regSel(regSel),
       .regWrData(regWrData), .regRdData(regRdData),
       .serviceDone(serviceDone), .serviceLevel(serviceLevel),
       .giveUpWait(giveUpWait), .instrBoundary(instrBoundary),
       .switchBusy(switchBusy), .runLevel(runLevel), .runValid(runValid),
       .ctxIndex(ctxIndex), .ctxSaveData(ctxSaveData),
       .ctxLoadStrobe(ctxLoadStrobe), .ctxLoadData(ctxLoadData),
       .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
       .memWrData(memWrData), .memRdData(memRdData),
       .instrCheck(instrCheck), .isPrivileged(isPrivileged),
       .isJump(isJump), .isStore(isStore), .fetchAddr(fetchAddr),
       .targetAddr(targetAddr), .instrSuppress(instrSuppress),
       .violationWait(violationWait));

   cpu_memory_model i_cpu_memory_model
      (.sys_clk(sys_clk), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
       .memWrData(memWrData), .memRdData(memRdData), .ctxIndex(ctxIndex),
       .runLevel(runLevel), .ctxSaveData(ctxSaveData));

   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
      if (ctxLoadStrobe === 1'b1)
         loadQ.push_back(ctxLoadData);

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask

   task automatic regWr(input logic [1:0] s, input logic [15:0] d);
      regSel = s;
      regWrData = d;
      regWrEn = 1'b1;
      tick();
      regWrEn = 1'b0;
      tick();
   endtask

   task automatic regRd(input logic [1:0] s, output logic [15:0] d);
      regSel = s;
      regRdEn = 1'b1;
      tick();
      regRdEn = 1'b0;
      d = regRdData;
      tick();
   endtask

   // Busy spans 38 memory cycles plus the closing cycle
   task automatic waitSwitch(input logic [3:0] lvl);
      int n;
      n = 0;
      loadQ.delete();
      while (switchBusy !== 1'b1 && n < 10)
      begin
         tick();
         n++;
      end
      n = 0;
      while (switchBusy === 1'b1 && n < 300)
      begin
         tick();
         n++;
      end
      if (n >= 300 || n == 0)
      begin
         n_errors++;
         stop_test();
      end
      else
      begin
         chk("busyCycles", 16'(n), 16'(SWITCH_MEM_CYC * MC + 1));
         chk("runLevel", {12'h000, runLevel}, {12'h000, lvl});
      end
   endtask

   task automatic chkCtx(input logic [15:0] ptr, input bit saved,
                         input logic [3:0] lvl);
      logic [15:0] e;
      chk("loadCount", 16'(loadQ.size()), 16'(CTX_WORDS));
      for (int i = 0; i < CTX_WORDS && i < loadQ.size(); i++)
      begin
         e = saved ? {8'hC0, 1'b0, 3'(i), lvl} : 16'h1000 + ptr + 16'(i);
         chk("ctxLoad", loadQ[i], e);
      end
   endtask

   task automatic t_regs;
      regRd(SEL_REQ_LATCH, rd);
      chk("latchRst", rd, 16'h0000);
      regRd(SEL_EN_MASK, rd);
      chk("maskRst", rd, 16'h0000);
      regWr(SEL_EN_MASK, 16'hA5C3);
      regRd(SEL_EN_MASK, rd);
      chk("mask", rd, 16'hA5C3);
      regWr(SEL_PROTECT, 16'h8001);
      regRd(SEL_PROTECT, rd);
      chk("protect", rd, 16'h8001);
      regWr(2'h3, 16'hFFFF);
      regRd(2'h3, rd);
      chk("sel3", rd, 16'h0000);
      $display("test regs done");
   endtask

   task automatic t_first;
      regWr(SEL_EN_MASK, 16'h0208);
      cpuReq[3] = 1'b1;
      tick();
      cpuReq[3] = 1'b0;
      repeat (4) tick();
      chk("busyNoBoundary", {15'h0, switchBusy}, 16'h0000);
      regRd(SEL_REQ_LATCH, rd);
      chk("latchHeld", rd, 16'h0008);
      instrBoundary = 1'b1;
      waitSwitch(4'h3);
      chkCtx(16'h0038, 1'b0, 4'h3);
      chk("runValid", {15'h0, runValid}, 16'h0001);
      $display("test first switch done");
   endtask

   task automatic t_higher;
      extReq[9] = 1'b1;
      tick();
      extReq[9] = 1'b0;
      waitSwitch(4'h9);
      chkCtx(16'h0068, 1'b0, 4'h9);
      for (int i = 0; i < 8; i++)
         chk("saved", i_cpu_memory_model.mem[8'h38 + i],
             {8'hC0, 1'b0, 3'(i), 4'h3});
      extReq[12] = 1'b1;
      tick();
      extReq[12] = 1'b0;
      repeat (5) tick();
      chk("disabledBusy", {15'h0, switchBusy}, 16'h0000);
      chk("disabledRun", {12'h0, runLevel}, 16'h0009);
      $display("test higher level done");
   endtask

   task automatic t_giveup;
      giveUpWait = 1'b1;
      tick();
      giveUpWait = 1'b0;
      waitSwitch(4'h3);
      chkCtx(16'h0038, 1'b1, 4'h3);
      regRd(SEL_REQ_LATCH, rd);
      chk("latchAfterWait", rd, 16'h1008);
      serviceLevel = 4'hC;
      serviceDone = 1'b1;
      tick();
      serviceDone = 1'b0;
      regRd(SEL_REQ_LATCH, rd);
      chk("latchServiced", rd, 16'h0008);
      serviceLevel = 4'h3;
      serviceDone = 1'b1;
      cpuReq[3] = 1'b1;
      tick();
      serviceDone = 1'b0;
      cpuReq[3] = 1'b0;
      regRd(SEL_REQ_LATCH, rd);
      chk("setWins", rd, 16'h0008);
      $display("test give up done");
   endtask

   // Block 0 protected; 0x03FF/0x0400 straddle the 1024-word edge
   task automatic t_protect;
      logic [34:0] tbl [6];
      tbl = '{{3'b100, 16'h0400, 16'h0000}, {3'b100, 16'h0010, 16'h0000},
              {3'b010, 16'h0400, 16'h0200}, {3'b010, 16'h0400, 16'h0800},
              {3'b001, 16'h0400, 16'h03FF}, {3'b001, 16'h0010, 16'h0020}};
      regWr(SEL_PROTECT, 16'h0001);
      for (int k = 0; k < 6; k++)
      begin
         {isPrivileged, isJump, isStore, fetchAddr, targetAddr} = tbl[k];
         instrCheck = 1'b1;
         #1;
         chk("suppress", {15'h0, instrSuppress}, 16'((k % 2) == 0));
         chk("noWait", {15'h0, violationWait}, 16'h0000);
         tick();
         instrCheck = 1'b0;
         tick();
         regRd(SEL_REQ_LATCH, rd);
         chk("violation", rd, (k % 2) == 0 ? 16'h4008 : 16'h0008);
         serviceLevel = VIOLATION_LVL;
         serviceDone = 1'b1;
         tick();
         serviceDone = 1'b0;
      end
      $display("test protect done");
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      t_regs();
      t_first();
      t_higher();
      t_giveup();
      t_protect();
      stop_test();
   end
endmodule
